// file: logic/uwaf_pkg.sv
// Purpose: shared constants and types of the wake and address filter block
// Assumes: 8-bit register port, 3-bit register address
// Notes: offsets are word indices on the plain register port
package uwaf_pkg;
    // ********************************************************
    // register map
    // ********************************************************
    localparam logic [2:0] ADDR_CTRL_A = 3'h0;
    localparam logic [2:0] ADDR_CTRL_B = 3'h1;
    localparam logic [2:0] ADDR_DATA = 3'h2;
    localparam logic [2:0] ADDR_STAT = 3'h3;
    localparam logic [2:0] ADDR_BAUD = 3'h4;
    localparam int CA_MPCM = 0;
    localparam int CA_TXC = 6;
    localparam int CA_RXC = 7;
    localparam int CB_SFDE = 0;
    localparam int CB_START_IRQ = 1;
    localparam int CB_CSZ = 2;
    localparam int CB_SBS = 5;
    localparam int CB_SYNC = 6;
    localparam int CB_U2X = 7;
    localparam int ST_RXB8 = 0;
    localparam int ST_FE = 1;
    localparam int ST_OSC = 2;
    localparam int ST_SCLK = 3;
    localparam logic [7:0] CTRL_B_RST = 8'h0c;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [2:0] CSZ_NINE = 3'h7;
    localparam logic [3:0] BITS_NINE = 4'h9;
    localparam logic [3:0] BITS_MIN = 4'h5;
    // ********************************************************
    // timing
    // ********************************************************
    localparam logic [4:0] SMP_NORMAL = 5'h10;
    localparam logic [4:0] SMP_DOUBLE = 5'h08;
    typedef enum logic [1:0] {
        UWAF_WK_IDLE = 2'b00,
        UWAF_WK_FRAME = 2'b01
    } uwaf_wake_t;
    typedef enum logic [1:0] {
        UWAF_RX_IDLE = 2'b00,
        UWAF_RX_START = 2'b01,
        UWAF_RX_DATA = 2'b10,
        UWAF_RX_STOP = 2'b11
    } uwaf_rx_t;
endpackage

// file: logic/uwaf_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: input is asynchronous to clk_in
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module uwaf_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic d_in,
    output logic q_out
);
    logic meta_reg;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_reg <= RST_VAL;
            q_out <= RST_VAL;
        end
        else
        begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule

// file: logic/uwaf_rx_core.sv
// Purpose: frame shifter, start bit to first stop bit
// Assumes: tick_in is the oversample pulse (async) or bit clock (sync)
// Notes: single centre sample per bit, no majority vote
`timescale 1ns/1ps
module uwaf_rx_core (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic tick_in,
    input wire logic sync_mode_in,
    input wire logic double_in,
    input wire logic [3:0] bits_in,
    input wire logic line_in,
    output logic done_out,
    output logic [8:0] data_out,
    output logic stop_out
);
    uwaf_pkg::uwaf_rx_t st_reg;
    logic [4:0] cnt_reg;
    logic [3:0] bitn_reg;
    logic [8:0] sh_reg;
    logic armed_reg;
    logic [4:0] full;
    logic [4:0] lim;
    logic samp;
    always_comb
    begin
        full = double_in ? uwaf_pkg::SMP_DOUBLE : uwaf_pkg::SMP_NORMAL;
        lim = (st_reg == uwaf_pkg::UWAF_RX_START) ? (full >> 1) - 5'h01 : full - 5'h01;
        samp = tick_in && (sync_mode_in || cnt_reg == lim);
    end
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st_reg <= uwaf_pkg::UWAF_RX_IDLE;
            cnt_reg <= 5'h00;
            bitn_reg <= 4'h0;
            sh_reg <= 9'h000;
            armed_reg <= 1'b0;
            done_out <= 1'b0;
            data_out <= 9'h000;
            stop_out <= 1'b0;
        end
        else
        begin
            done_out <= 1'b0;
            if (tick_in)
            begin
                cnt_reg <= samp ? 5'h00 : cnt_reg + 5'h01;
            end
            if (!enable_in)
            begin
                st_reg <= uwaf_pkg::UWAF_RX_IDLE;
                // keep tracking the idle line, else the start that wakes the clocks is lost
                armed_reg <= armed_reg | line_in;
            end
            else
            begin
                case (st_reg)
                    uwaf_pkg::UWAF_RX_IDLE:
                    begin
                        // a line stuck low must go high once before a start counts
                        armed_reg <= armed_reg | line_in;
                        cnt_reg <= 5'h00;
                        if (armed_reg && !line_in)
                        begin
                            st_reg <= uwaf_pkg::UWAF_RX_START;
                        end
                    end
                    uwaf_pkg::UWAF_RX_START:
                    begin
                        bitn_reg <= 4'h0;
                        if (samp)
                        begin
                            st_reg <= line_in ? uwaf_pkg::UWAF_RX_IDLE : uwaf_pkg::UWAF_RX_DATA;
                        end
                    end
                    uwaf_pkg::UWAF_RX_DATA:
                    begin
                        if (samp)
                        begin
                            sh_reg <= {line_in, sh_reg[8:1]};
                            bitn_reg <= bitn_reg + 4'h1;
                            if (bitn_reg + 4'h1 == bits_in)
                            begin
                                st_reg <= uwaf_pkg::UWAF_RX_STOP;
                            end
                        end
                    end
                    default:
                    begin
                        if (samp)
                        begin
                            done_out <= 1'b1;
                            data_out <= sh_reg >> (uwaf_pkg::BITS_NINE - bits_in);
                            stop_out <= line_in;
                            armed_reg <= line_in;
                            st_reg <= uwaf_pkg::UWAF_RX_IDLE;
                        end
                    end
                endcase
            end
        end
    end
endmodule

// file: logic/uwaf_top.sv
// Purpose: serial receiver start-frame wake and multi-processor address filter
// Assumes: clk_in keeps running for this block while the core sleeps
// Notes: oscillator and clock gating are requests to the power manager
`timescale 1ns/1ps
module uwaf_top (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic receive_line_in,
    input wire logic serial_clock_in,
    input wire logic sleep_active_in,
    input wire logic tx_done_in,
    output logic osc_request_out,
    output logic serial_clk_enable_out,
    output logic cpu_wake_out,
    output logic rx_start_irq_out,
    output logic rx_complete_irq_out
);
    // ********************************************************
    // declarations
    // ********************************************************
    logic multiproc_filter_enable_reg;
    logic transmit_complete_flag_reg;
    logic receive_complete_flag_reg;
    logic [7:0] ctrl_b_reg;
    logic [7:0] baud_divisor_reg;
    logic [7:0] serial_data_reg;
    logic received_ninth_bit_reg;
    logic frame_error_reg;
    logic [7:0] baud_cnt_reg;
    logic sclk_last_reg;
    logic line_last_reg;
    uwaf_pkg::uwaf_wake_t wake_reg;
    logic line_s;
    logic sclk_s;
    logic baud_tick;
    logic rx_tick;
    logic rx_enable;
    logic falling;
    logic done;
    logic [8:0] frame_data;
    logic frame_stop;
    logic frame_type;
    logic store;
    logic start_frame_detect_enable;
    logic receive_start_irq_enable;
    logic [2:0] character_size_select;
    logic sync_mode;
    logic double_speed_select;
    logic [3:0] frame_bits;
    logic data_read;
    logic [7:0] rd_mux;

    // ********************************************************
    // helpers
    // ********************************************************
    function automatic logic [3:0] bits_of(input logic [2:0] csz);
        logic [3:0] n;
        n = uwaf_pkg::BITS_MIN + {1'b0, csz};
        if (csz == uwaf_pkg::CSZ_NINE)
        begin
            n = uwaf_pkg::BITS_NINE;
        end
        return n;
    endfunction

    function automatic logic is_nine(input logic [2:0] csz);
        return bits_of(csz) == uwaf_pkg::BITS_NINE;
    endfunction

    // ********************************************************
    // pin synchronisers
    // ********************************************************
    uwaf_sync #(
        .RST_VAL(1'b1)
    ) u_line_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .d_in(receive_line_in),
        .q_out(line_s)
    );

    uwaf_sync #(
        .RST_VAL(1'b0)
    ) u_sclk_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .d_in(serial_clock_in),
        .q_out(sclk_s)
    );

    // ********************************************************
    // control fields
    // ********************************************************
    always_comb
    begin
        start_frame_detect_enable = ctrl_b_reg[uwaf_pkg::CB_SFDE];
        receive_start_irq_enable = ctrl_b_reg[uwaf_pkg::CB_START_IRQ];
        character_size_select = ctrl_b_reg[uwaf_pkg::CB_CSZ +: 3];
        sync_mode = ctrl_b_reg[uwaf_pkg::CB_SYNC];
        double_speed_select = ctrl_b_reg[uwaf_pkg::CB_U2X];
        frame_bits = bits_of(character_size_select);
        data_read = rd_in && addr_in == uwaf_pkg::ADDR_DATA;
    end

    // ********************************************************
    // sample clock: divider in async mode, pin edge in sync mode
    // ********************************************************
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            baud_cnt_reg <= 8'h00;
            sclk_last_reg <= 1'b0;
            line_last_reg <= 1'b1;
        end
        else
        begin
            baud_cnt_reg <= baud_tick ? baud_divisor_reg : baud_cnt_reg - 8'h01;
            sclk_last_reg <= sclk_s;
            line_last_reg <= line_s;
        end
    end

    always_comb
    begin
        baud_tick = baud_cnt_reg == 8'h00;
        // sync bit clock kept below the sampling limits by the sender
        rx_tick = sync_mode ? (sclk_s && !sclk_last_reg) : baud_tick;
        falling = line_last_reg && !line_s;
        // receiver runs while awake or while the wake request holds the clocks
        rx_enable = !sleep_active_in || wake_reg == uwaf_pkg::UWAF_WK_FRAME;
    end

    // ********************************************************
    // receive engine
    // ********************************************************
    uwaf_rx_core u_core (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .enable_in(rx_enable),
        .tick_in(rx_tick),
        .sync_mode_in(sync_mode),
        .double_in(double_speed_select),
        .bits_in(frame_bits),
        .line_in(line_s),
        .done_out(done),
        .data_out(frame_data),
        .stop_out(frame_stop)
    );

    // ********************************************************
    // address filter
    // ********************************************************
    always_comb
    begin
        // frame type bit, one for address, zero for data
        frame_type = is_nine(character_size_select) ? frame_data[8] : frame_stop;
        // data frames are dropped while filtering; address frames pass
        store = done && !(multiproc_filter_enable_reg && !frame_type);
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            serial_data_reg <= 8'h00;
            received_ninth_bit_reg <= 1'b0;
            frame_error_reg <= 1'b0;
        end
        else if (store)
        begin
            serial_data_reg <= frame_data[7:0];
            received_ninth_bit_reg <= frame_data[8];
            frame_error_reg <= !frame_stop;
        end
    end

    // ********************************************************
    // receive complete flag: set wins over read clear
    // ********************************************************
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            receive_complete_flag_reg <= 1'b0;
        end
        else if (store)
        begin
            receive_complete_flag_reg <= 1'b1;
        end
        else if (data_read)
        begin
            receive_complete_flag_reg <= 1'b0;
        end
    end

    // ********************************************************
    // transmit complete flag, independent of filtering
    // ********************************************************
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            transmit_complete_flag_reg <= 1'b0;
        end
        else if (tx_done_in)
        begin
            transmit_complete_flag_reg <= 1'b1;
        end
        else if (wr_in && addr_in == uwaf_pkg::ADDR_CTRL_A && wdata_in[uwaf_pkg::CA_TXC])
        begin
            // write-one-clear, so rewriting the control word can drop it
            transmit_complete_flag_reg <= 1'b0;
        end
    end

    // ********************************************************
    // control registers
    // ********************************************************
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            multiproc_filter_enable_reg <= 1'b0;
            ctrl_b_reg <= uwaf_pkg::CTRL_B_RST;
            baud_divisor_reg <= uwaf_pkg::BAUD_RST;
        end
        else if (wr_in)
        begin
            case (addr_in)
                uwaf_pkg::ADDR_CTRL_A:
                begin
                    // software toggles it per address, no hardware change
                    multiproc_filter_enable_reg <= wdata_in[uwaf_pkg::CA_MPCM];
                end
                uwaf_pkg::ADDR_CTRL_B:
                begin
                    ctrl_b_reg <= wdata_in;
                end
                uwaf_pkg::ADDR_BAUD:
                begin
                    baud_divisor_reg <= wdata_in;
                end
                default:
                begin
                    baud_divisor_reg <= baud_divisor_reg;
                end
            endcase
        end
    end

    // ********************************************************
    // start-frame wake controller
    // ********************************************************
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wake_reg <= uwaf_pkg::UWAF_WK_IDLE;
            osc_request_out <= 1'b0;
            rx_start_irq_out <= 1'b0;
            cpu_wake_out <= 1'b0;
        end
        else
        begin
            rx_start_irq_out <= 1'b0;
            cpu_wake_out <= 1'b0;
            case (wake_reg)
                uwaf_pkg::UWAF_WK_IDLE:
                begin
                    // same edge test in async and sync modes, gated by enable
                    if (sleep_active_in && start_frame_detect_enable && falling)
                    begin
                        wake_reg <= uwaf_pkg::UWAF_WK_FRAME;
                        osc_request_out <= 1'b1;
                        if (receive_start_irq_enable)
                        begin
                            rx_start_irq_out <= 1'b1;
                            cpu_wake_out <= 1'b1;
                        end
                    end
                end
                uwaf_pkg::UWAF_WK_FRAME:
                begin
                    if (!sleep_active_in || done)
                    begin
                        // oscillator start-up is not modelled; slow baud covers it
                        wake_reg <= uwaf_pkg::UWAF_WK_IDLE;
                        osc_request_out <= 1'b0;
                        // only a kept frame wakes the core; filtered ones sleep on
                        cpu_wake_out <= store && sleep_active_in;
                    end
                end
                default:
                begin
                    wake_reg <= uwaf_pkg::UWAF_WK_IDLE;
                    osc_request_out <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            serial_clk_enable_out <= 1'b1;
            rx_complete_irq_out <= 1'b0;
        end
        else
        begin
            // in sleep the serial clock follows the frame, other clocks stay off
            serial_clk_enable_out <= !sleep_active_in
                || (wake_reg == uwaf_pkg::UWAF_WK_IDLE && sleep_active_in
                    && start_frame_detect_enable && falling)
                || (wake_reg == uwaf_pkg::UWAF_WK_FRAME && !done);
            rx_complete_irq_out <= receive_complete_flag_reg;
        end
    end

    // ********************************************************
    // register read port
    // ********************************************************
    always_comb
    begin
        rd_mux = 8'h00;
        case (addr_in)
            uwaf_pkg::ADDR_CTRL_A:
            begin
                rd_mux[uwaf_pkg::CA_MPCM] = multiproc_filter_enable_reg;
                rd_mux[uwaf_pkg::CA_TXC] = transmit_complete_flag_reg;
                rd_mux[uwaf_pkg::CA_RXC] = receive_complete_flag_reg;
            end
            uwaf_pkg::ADDR_CTRL_B:
            begin
                rd_mux = ctrl_b_reg;
            end
            uwaf_pkg::ADDR_DATA:
            begin
                rd_mux = serial_data_reg;
            end
            uwaf_pkg::ADDR_STAT:
            begin
                rd_mux[uwaf_pkg::ST_RXB8] = received_ninth_bit_reg;
                rd_mux[uwaf_pkg::ST_FE] = frame_error_reg;
                rd_mux[uwaf_pkg::ST_OSC] = osc_request_out;
                rd_mux[uwaf_pkg::ST_SCLK] = serial_clk_enable_out;
            end
            uwaf_pkg::ADDR_BAUD:
            begin
                rd_mux = baud_divisor_reg;
            end
            default:
            begin
                rd_mux = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rdata_out <= 8'h00;
        end
        else
        begin
            // data stands only in the cycle after the read strobe
            rdata_out <= rd_in ? rd_mux : 8'h00;
        end
    end
endmodule

// file: dv/uwaf_chk.sv
// Purpose: port-level checker of the wake and address filter block
// Assumes: detector enables are shadowed from bus writes
// Notes: bound to every uwaf_top instance
`timescale 1ns/1ps
module uwaf_chk (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic receive_line_in,
    input wire logic sleep_active_in,
    input wire logic osc_request_out,
    input wire logic serial_clk_enable_out,
    input wire logic cpu_wake_out,
    input wire logic rx_start_irq_out,
    input wire logic rx_complete_irq_out
);
    // ************************************************
    // enable shadow and properties
    // ************************************************
    logic sfde_reg;
    logic sie_reg;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sfde_reg <= 1'b0;
            sie_reg <= 1'b0;
        end
        else if (wr_in && addr_in == uwaf_pkg::ADDR_CTRL_B)
        begin
            sfde_reg <= wdata_in[uwaf_pkg::CB_SFDE];
            sie_reg <= wdata_in[uwaf_pkg::CB_START_IRQ];
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    a_osc_needs_en: assert property ($rose(osc_request_out) |-> sfde_reg && $past(sleep_active_in))
        else $error("oscillator request without enabled detector");
    a_osc_on_fall: assert property ($fell(receive_line_in) && sleep_active_in && sfde_reg
        && !osc_request_out |-> ##[1:6] osc_request_out)
        else $error("start edge did not request oscillator");
    a_sclk_with_osc: assert property (osc_request_out |-> serial_clk_enable_out)
        else $error("serial clock off during wake frame");
    a_sirq_cause: assert property (rx_start_irq_out |-> osc_request_out && sie_reg)
        else $error("start interrupt without cause");
    a_sirq_prompt: assert property ($rose(osc_request_out) && sie_reg
        |-> rx_start_irq_out && cpu_wake_out)
        else $error("start interrupt late");
    a_quiet_start: assert property ($rose(osc_request_out) && !sie_reg
        |-> !cpu_wake_out && !rx_start_irq_out)
        else $error("core woken at start without interrupt");
    a_wake_needs_en: assert property (cpu_wake_out |-> sfde_reg)
        else $error("wake with detector disabled");
    a_sirq_pulse: assert property (rx_start_irq_out |=> !rx_start_irq_out)
        else $error("start interrupt longer than one cycle");
    a_irq_tracks_flag: assert property ($past(rd_in) && $past(addr_in) == uwaf_pkg::ADDR_CTRL_A
        |-> rx_complete_irq_out == rdata_out[uwaf_pkg::CA_RXC])
        else $error("receive complete interrupt differs from flag");
    c_start_irq: cover property (rx_start_irq_out);
    c_wake: cover property (cpu_wake_out);
    c_flag_read: cover property (rd_in ##1 rdata_out[uwaf_pkg::CA_RXC]);
    c_quiet_wake: cover property ($fell(osc_request_out) && cpu_wake_out);
endmodule

bind uwaf_top uwaf_chk u_chk (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .receive_line_in, .sleep_active_in, .osc_request_out, .serial_clk_enable_out,
    .cpu_wake_out, .rx_start_irq_out, .rx_complete_irq_out);

// file: dv/uwaf_far_tx.sv
// Purpose: far-side serial sender driving the receive line
// Assumes: one bit lasts BIT clocks, no baud error
// Notes: line idles high as on a pulled-up shared bus
`timescale 1ns/1ps
module uwaf_far_tx #(
    parameter int BIT = 16
) (
    input wire logic clk_in,
    output logic line_out,
    output logic sclk_out
);
    // ************************************************
    // frame sender
    // ************************************************
    initial line_out = 1'b1;
    initial sclk_out = 1'b0;
    // one bit per slot; the bit clock rises mid-slot and rests low between frames
    task automatic slot(input logic b);
        line_out <= b;
        repeat (BIT / 2) @(posedge clk_in);
        sclk_out <= 1'b1;
        repeat (BIT / 2) @(posedge clk_in);
        sclk_out <= 1'b0;
    endtask
    // type bit goes in the first stop slot, so a second stop always follows
    task automatic send(input int nb, input logic [8:0] d, input logic ty);
        int i;
        @(posedge clk_in);
        slot(1'b0);
        for (i = 0; i < nb; i++)
        begin
            slot(d[i]);
        end
        slot(ty);
        slot(1'b1);
        slot(1'b1);
    endtask
endmodule

// file: dv/tb.sv
// Purpose: self-checking bench of the wake and address filter block
// Assumes: baud divisor 0 (1 in the double speed test), one bit is 16 clocks
// Notes: far model pulses the sync bit clock mid-bit in every frame
`timescale 1ns/1ps
module tb;
    // ************************************************
    // stimulus and checks
    // ************************************************
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [2:0] addr_in = 3'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic sleep_in = 1'b0;
    logic txd_in = 1'b0;
    logic line, sclk, osc, wake, sirq;
    logic osc_d = 1'b0;
    logic [7:0] rdata;
    logic [7:0] cfg [4] = '{8'h1f, 8'h1d, 8'h5d, 8'h1c};
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    int k, n_sirq, n_wake, n_osc, b_sirq, b_wake, b_osc;
    always #5 clk_in = ~clk_in;
    uwaf_far_tx #(.BIT(16)) far (.clk_in, .line_out(line), .sclk_out(sclk));
    uwaf_top dut (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out(rdata),
        .receive_line_in(line), .serial_clock_in(sclk), .sleep_active_in(sleep_in),
        .tx_done_in(txd_in), .osc_request_out(osc), .serial_clk_enable_out(),
        .cpu_wake_out(wake), .rx_start_irq_out(sirq), .rx_complete_irq_out());
    always @(posedge clk_in)
    begin
        cyc++;
        n_sirq += sirq;
        n_wake += wake;
        n_osc += osc & ~osc_d;
        osc_d = osc;
        if (cyc == 20000)
        begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 check(rdata, exp);
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(uwaf_pkg::ADDR_CTRL_B, 8'h0c);
        rd(uwaf_pkg::ADDR_BAUD, 8'h00);
        wr(3'h6, 8'hff);
        rd(3'h6, 8'h00);
        $display("test reset done");
        wr(uwaf_pkg::ADDR_CTRL_B, 8'h1d);
        wr(uwaf_pkg::ADDR_CTRL_A, 8'h01);
        far.send(9, 9'h055, 1'b1);
        rd(uwaf_pkg::ADDR_CTRL_A, 8'h01);
        far.send(9, 9'h1a5, 1'b1);
        rd(uwaf_pkg::ADDR_CTRL_A, 8'h81);
        rd(uwaf_pkg::ADDR_STAT, 8'h09);
        rd(uwaf_pkg::ADDR_DATA, 8'ha5);
        wr(uwaf_pkg::ADDR_CTRL_A, 8'h00);
        far.send(9, 9'h03c, 1'b1);
        rd(uwaf_pkg::ADDR_DATA, 8'h3c);
        rd(uwaf_pkg::ADDR_STAT, 8'h08);
        $display("test nine-bit filter done");
        wr(uwaf_pkg::ADDR_CTRL_A, 8'h01);
        wr(uwaf_pkg::ADDR_CTRL_B, 8'h2d);
        far.send(8, 9'h077, 1'b0);
        rd(uwaf_pkg::ADDR_CTRL_A, 8'h01);
        far.send(8, 9'h04e, 1'b1);
        rd(uwaf_pkg::ADDR_DATA, 8'h4e);
        $display("test eight-bit filter done");
        @(posedge clk_in) txd_in <= 1'b1;
        @(posedge clk_in) txd_in <= 1'b0;
        rd(uwaf_pkg::ADDR_CTRL_A, 8'h41);
        wr(uwaf_pkg::ADDR_CTRL_A, 8'h40);
        rd(uwaf_pkg::ADDR_CTRL_A, 8'h00);
        $display("test transmit flag done");
        wr(uwaf_pkg::ADDR_BAUD, 8'h01);
        wr(uwaf_pkg::ADDR_CTRL_B, 8'h9c);
        far.send(9, 9'h1c3, 1'b1);
        rd(uwaf_pkg::ADDR_DATA, 8'hc3);
        rd(uwaf_pkg::ADDR_BAUD, 8'h01);
        wr(uwaf_pkg::ADDR_BAUD, 8'h00);
        $display("test double speed done");
        // interrupt on, interrupt off, sync mode, detector off
        for (k = 0; k < 4; k++)
        begin
            wr(uwaf_pkg::ADDR_CTRL_B, cfg[k]);
            sleep_in <= 1'b1;
            b_sirq = n_sirq;
            b_wake = n_wake;
            b_osc = n_osc;
            far.send(9, 9'h011, 1'b1);
            sleep_in <= 1'b0;
            check(8'(n_sirq - b_sirq), (k == 0) ? 8'h01 : 8'h00);
            check(8'(n_wake - b_wake), (k == 0) ? 8'h02 : ((k == 3) ? 8'h00 : 8'h01));
            check(8'(n_osc - b_osc), (k == 3) ? 8'h00 : 8'h01);
            rd(uwaf_pkg::ADDR_CTRL_A, (k == 3) ? 8'h00 : 8'h80);
            rd(uwaf_pkg::ADDR_DATA, 8'h11);
            $display("test wake case %0d done", k);
        end
        tally_and_finish();
    end
endmodule
